/* common/emr_map.svh */
`ifndef EMR_MAP_SVH
`define EMR_MAP_SVH

`define EMR_DW 36
`define EMR_AW 12
`define EMR_WA 7
`define EMR_WORDS 128
`define EMR_WMASK_SMALL 7'h0f
`define EMR_WMASK_FULL 7'h7f
`define EMR_UNDEF_FILL 36'hf_ffff_ffff

`define EMR_CFG_OFS 12'h000
`define EMR_STAT_OFS 12'h004

`define EMR_CFG_BITS 15
`define EMR_CFG_RST 15'h4405
`define EMR_CFG_SIZE_LSB 0
`define EMR_CFG_MODE_LSB 2
`define EMR_CFG_AOREG_BIT 4
`define EMR_CFG_BOREG_BIT 5
`define EMR_CFG_FLOW_BIT 6
`define EMR_CFG_AW_LSB 7
`define EMR_CFG_BW_LSB 11

`define EMR_STAT_COLL_BIT 0
`define EMR_STAT_SPC_BIT 1
`define EMR_STAT_CERR_BIT 2
`define EMR_STAT_UNDEF_BIT 3

`endif

/* common/emr_pkg.sv */
package emr_pkg;
   typedef enum logic [1:0] {SZ_SMALL, SZ_MEDIUM, SZ_LARGE, SZ_RSVD} emr_size_t;
   typedef enum logic [1:0] {MD_SINGLE, MD_SIMPLE, MD_TRUE, MD_SPLIT} emr_mode_t;
   typedef enum logic [3:0] {W1, W2, W4, W8, W16, W32, W9, W18, W36} emr_width_t;
   typedef struct packed {
      logic [6:0] word;
      logic [5:0] off;
      logic [35:0] mask;
   } emr_lane_t;
endpackage

/* verilog/emr_dpram.sv */
`timescale 1ns/1ps
`include "emr_map.svh"
module emr_dpram
   import emr_pkg::*;
(
   // clock
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // port a
   input wire logic a_we,
   input wire logic [6:0] a_wword,
   input wire logic [35:0] a_wmask,
   input wire logic [35:0] a_wdata,
   input wire logic a_re,
   input wire logic [6:0] a_rword,
   input wire logic a_wt,
   output logic [35:0] a_rdata,
   // port b
   input wire logic b_we,
   input wire logic [6:0] b_wword,
   input wire logic [35:0] b_wmask,
   input wire logic [35:0] b_wdata,
   input wire logic b_re,
   input wire logic [6:0] b_rword,
   input wire logic b_wt,
   output logic [35:0] b_rdata
);
   logic [`EMR_DW-1:0] mem [0:`EMR_WORDS-1];
   logic [35:0] a_new, b_base, b_new, a_rd_nxt, b_rd_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // merged masked writes; same word keeps both lanes
   always_comb begin
      a_new = (mem[a_wword] & ~a_wmask) | (a_wdata & a_wmask);
      b_base = (a_we && a_wword == b_wword) ? a_new : mem[b_wword];
      b_new = (b_base & ~b_wmask) | (b_wdata & b_wmask);
      // reads see old data unless the same port writes through
      a_rd_nxt = (a_wt && a_we && a_rword == a_wword) ? a_new : mem[a_rword];
      b_rd_nxt = (b_wt && b_we && b_rword == b_wword) ? b_new : mem[b_rword];
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         if (a_we) begin
            mem[a_wword] <= a_new;
         end
         if (b_we) begin
            mem[b_wword] <= b_new;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         a_rdata <= 36'h0_0000_0000;
         b_rdata <= 36'h0_0000_0000;
      end else if (ce) begin
         if (a_re) begin
            a_rdata <= a_rd_nxt;
         end
         if (b_re) begin
            b_rdata <= b_rd_nxt;
         end
      end
   end
endmodule

/* verilog/emr_ahb_regs.sv */
`timescale 1ns/1ps
`include "emr_map.svh"
module emr_ahb_regs
   import emr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // block side
   input wire logic coll_pulse,
   input wire logic spc_pulse,
   input wire logic cfg_err,
   input wire logic undef_any,
   output logic [`EMR_CFG_BITS-1:0] cfg
);
   logic take;
   logic dph_wr_r, dph_wr_nxt;
   logic [11:0] dph_addr_r, dph_addr_nxt;
   logic [`EMR_CFG_BITS-1:0] cfg_r, cfg_nxt;
   logic [1:0] stat_r, stat_nxt;
   logic [31:0] rd_r, rd_nxt;

   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = rd_r;
   assign cfg = cfg_r;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      take = hsel && hready && htrans[1] && ce && hsize == 3'h2;
      dph_wr_nxt = take && hwrite;
      dph_addr_nxt = take ? haddr[11:0] : dph_addr_r;
      rd_nxt = 32'h0000_0000;
      if (take && !hwrite) begin
         if (haddr[11:0] == `EMR_CFG_OFS) begin
            rd_nxt = {17'h0_0000, cfg_r};
         end else if (haddr[11:0] == `EMR_STAT_OFS) begin
            rd_nxt = {28'h000_0000, undef_any, cfg_err, stat_r};
         end
      end
      cfg_nxt = cfg_r;
      stat_nxt = stat_r;
      if (dph_wr_r && dph_addr_r == `EMR_CFG_OFS) begin
         cfg_nxt = hwdata[`EMR_CFG_BITS-1:0];
      end
      if (dph_wr_r && dph_addr_r == `EMR_STAT_OFS) begin
         stat_nxt = stat_r & ~hwdata[1:0];
      end
      // set wins over a same-cycle clear
      stat_nxt[`EMR_STAT_COLL_BIT] = stat_nxt[`EMR_STAT_COLL_BIT] | coll_pulse;
      stat_nxt[`EMR_STAT_SPC_BIT] = stat_nxt[`EMR_STAT_SPC_BIT] | spc_pulse;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dph_wr_r <= 1'b0;
         dph_addr_r <= 12'h000;
         cfg_r <= `EMR_CFG_RST;
         stat_r <= 2'h0;
         rd_r <= 32'h0000_0000;
      end else if (ce) begin
         dph_wr_r <= dph_wr_nxt;
         dph_addr_r <= dph_addr_nxt;
         cfg_r <= cfg_nxt;
         stat_r <= stat_nxt;
         rd_r <= rd_nxt;
      end
   end
endmodule

/* verilog/emr_ram_top.sv */
// How it works
// - medium/large: two ports, any read/write mix
// - simple dual collision: old data or undefined
// - single port: no simultaneous access; write-through
// - registered output shows write one edge later
// - all inputs captured in input registers
// - self-timed internal write strobe from clock
// - output register optional, bypass adds no cycle
// - flow-through read (simple dual, small/medium): falling-edge read address
// - ports may use different data widths
// - clears: small/medium all, large output only
// - large block: no init, ROM by writing
// - medium block splits into two half memories
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "emr_map.svh"
module emr_ram_top
   import emr_pkg::*;
(
   // clock, clock enable, reset
   input wire logic ref_clk,
   input wire logic clk_en,
   input wire logic rst_b,
   // ahb-lite register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // register clears
   input wire logic in_clr,
   input wire logic out_clr,
   // port a
   input wire logic a_ena,
   input wire logic [11:0] a_addr,
   input wire logic [35:0] a_din,
   input wire logic a_wren,
   input wire logic a_rden,
   output logic [35:0] a_q,
   // port b
   input wire logic b_ena,
   input wire logic [11:0] b_addr,
   input wire logic [35:0] b_din,
   input wire logic b_wren,
   input wire logic b_rden,
   output logic [35:0] b_q
);
   ////////////////////////////////////////////////////////////////////////////
   // lane decode: word, bit offset and mask of one element
   function automatic emr_lane_t lane_of(input emr_width_t w, input logic [11:0] a,
                                         input logic [6:0] wm, input logic split,
                                         input logic top);
      emr_lane_t l;
      logic [2:0] sh;
      logic [5:0] wb;
      logic [11:0] idx;
      case (w)
         W1: begin sh = 3'h5; wb = 6'h01; end
         W2: begin sh = 3'h4; wb = 6'h02; end
         W4: begin sh = 3'h3; wb = 6'h04; end
         W8: begin sh = 3'h2; wb = 6'h08; end
         W16: begin sh = 3'h1; wb = 6'h10; end
         W32: begin sh = 3'h0; wb = 6'h20; end
         W9: begin sh = 3'h2; wb = 6'h09; end
         W18: begin sh = 3'h1; wb = 6'h12; end
         default: begin sh = 3'h0; wb = 6'h24; end
      endcase
      l.word = 7'(a >> sh) & wm;
      if (split) begin
         l.word = (l.word & (wm >> 1)) | (top ? (wm & ~(wm >> 1)) : 7'h00);
      end
      idx = a & ((12'h001 << sh) - 12'h001);
      l.off = 6'(idx * wb);
      l.mask = ((36'h1 << wb) - 36'h1) << l.off;
      return l;
   endfunction

   function automatic logic is_par(input emr_width_t w);
      return w == W9 || w == W18 || w == W36;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration decode
   logic [`EMR_CFG_BITS-1:0] cfg;
   emr_size_t size;
   emr_mode_t mode_cfg, mode;
   emr_width_t wid [2];
   logic oreg [2];
   logic flow, cfg_err, undef_any, coll, spc_pulse;
   logic [6:0] wmask;
   logic can_wr [2];
   logic can_rd [2];
   logic wt [2];

   always_comb begin
      size = emr_size_t'(cfg[`EMR_CFG_SIZE_LSB +: 2]);
      mode_cfg = emr_mode_t'(cfg[`EMR_CFG_MODE_LSB +: 2]);
      wid[0] = emr_width_t'(cfg[`EMR_CFG_AW_LSB +: 4]);
      wid[1] = emr_width_t'(cfg[`EMR_CFG_BW_LSB +: 4]);
      oreg[0] = cfg[`EMR_CFG_AOREG_BIT];
      oreg[1] = cfg[`EMR_CFG_BOREG_BIT];
      // small block has no true dual-port; it falls back to simple
      mode = (mode_cfg == MD_TRUE && size == SZ_SMALL) ? MD_SIMPLE : mode_cfg;
      flow = cfg[`EMR_CFG_FLOW_BIT] && mode == MD_SIMPLE && size != SZ_LARGE;
      wmask = (size == SZ_SMALL) ? `EMR_WMASK_SMALL : `EMR_WMASK_FULL;
      cfg_err = size == SZ_RSVD || cfg[`EMR_CFG_AW_LSB +: 4] > 4'h8
                || cfg[`EMR_CFG_BW_LSB +: 4] > 4'h8
                || (mode_cfg == MD_TRUE && size == SZ_SMALL)
                || (mode_cfg == MD_SPLIT && size != SZ_MEDIUM)
                || (mode_cfg != MD_SINGLE && is_par(wid[0]) != is_par(wid[1]));
      can_wr[0] = 1'b1;
      can_rd[0] = mode != MD_SIMPLE;
      can_wr[1] = mode == MD_TRUE || mode == MD_SPLIT;
      can_rd[1] = mode != MD_SINGLE;
      wt[0] = mode == MD_SINGLE || mode == MD_SPLIT;
      wt[1] = mode == MD_SPLIT;
      spc_pulse = clk_en && a_ena && mode == MD_SINGLE && a_wren && a_rden;
   end

   ////////////////////////////////////////////////////////////////////////////
   // port state
   logic ena_i [2];
   logic [11:0] addr_i [2];
   logic [35:0] din_i [2];
   logic wren_i [2];
   logic rden_i [2];
   logic [35:0] q_o [2];
   logic [11:0] addr_r [2], addr_nxt [2];
   logic [35:0] din_r [2], din_nxt [2];
   logic we_r [2], we_nxt [2], re_r [2], re_nxt [2], stb_r [2], stb_nxt [2];
   logic m_we [2], m_re [2];
   emr_lane_t lw [2], lr [2], rl_d_r [2], rl_d_nxt [2];
   logic [35:0] m_wdata [2], m_rdata [2], unreg [2], oq_r [2], oq_nxt [2];
   logic rd_d_r [2], rd_d_nxt [2], known_r [2], known_nxt [2], shown_undef [2];
   logic [11:0] nraddr_r, nraddr_nxt;
   logic nre_r, nre_nxt, coll_d_r;

   assign ena_i[0] = a_ena;
   assign ena_i[1] = b_ena;
   assign addr_i[0] = a_addr;
   assign addr_i[1] = b_addr;
   assign din_i[0] = a_din;
   assign din_i[1] = b_din;
   assign wren_i[0] = a_wren;
   assign wren_i[1] = b_wren;
   assign rden_i[0] = a_rden;
   assign rden_i[1] = b_rden;
   assign a_q = q_o[0];
   assign b_q = q_o[1];
   assign undef_any = shown_undef[0] | shown_undef[1];

   for (genvar p = 0; p < 2; p++) begin : g_port
      localparam logic IS_B = (p == 1);

      always_comb begin
         addr_nxt[p] = addr_r[p];
         din_nxt[p] = din_r[p];
         we_nxt[p] = we_r[p];
         re_nxt[p] = re_r[p];
         stb_nxt[p] = 1'b0;
         if (in_clr && size != SZ_LARGE) begin
            addr_nxt[p] = 12'h000;
            din_nxt[p] = 36'h0_0000_0000;
            we_nxt[p] = 1'b0;
            re_nxt[p] = 1'b0;
         end else if (ena_i[p]) begin
            addr_nxt[p] = addr_i[p];
            din_nxt[p] = din_i[p];
            we_nxt[p] = wren_i[p] && can_wr[p];
            // a write beats a read issued with it on a single port
            re_nxt[p] = rden_i[p] && can_rd[p] && !(mode == MD_SINGLE && wren_i[p]);
            stb_nxt[p] = 1'b1;
         end
      end

      always_ff @(posedge ref_clk or negedge rst_b) begin
         if (!rst_b) begin
            addr_r[p] <= 12'h000;
            din_r[p] <= 36'h0_0000_0000;
            we_r[p] <= 1'b0;
            re_r[p] <= 1'b0;
            stb_r[p] <= 1'b0;
         end else if (clk_en) begin
            addr_r[p] <= addr_nxt[p];
            din_r[p] <= din_nxt[p];
            we_r[p] <= we_nxt[p];
            re_r[p] <= re_nxt[p];
            stb_r[p] <= stb_nxt[p];
         end
      end

      // array hookup, read lane pipeline and output stage
      always_comb begin
         lw[p] = lane_of(wid[p], addr_r[p], wmask, mode == MD_SPLIT, IS_B);
         m_we[p] = we_r[p] && stb_r[p];
         m_wdata[p] = din_r[p] << lw[p].off;
         if (IS_B && flow) begin
            lr[p] = lane_of(wid[p], nraddr_r, wmask, 1'b0, IS_B);
            m_re[p] = nre_r;
         end else begin
            lr[p] = lane_of(wid[p], addr_r[p], wmask, mode == MD_SPLIT, IS_B);
            m_re[p] = stb_r[p] && (re_r[p] || (wt[p] && we_r[p]));
         end
         rl_d_nxt[p] = m_re[p] ? lr[p] : rl_d_r[p];
         rd_d_nxt[p] = m_re[p];
         unreg[p] = (m_rdata[p] & rl_d_r[p].mask) >> rl_d_r[p].off;
         oq_nxt[p] = out_clr ? 36'h0_0000_0000 : unreg[p];
         known_nxt[p] = known_r[p] || rd_d_r[p];
         if (IS_B && coll_d_r && size == SZ_LARGE) begin
            known_nxt[p] = 1'b0;
         end
         if (out_clr) begin
            known_nxt[p] = 1'b1;
         end
         // large block output is undefined until first read or clear
         shown_undef[p] = size == SZ_LARGE && !(out_clr || known_nxt[p]);
         if (shown_undef[p]) begin
            q_o[p] = `EMR_UNDEF_FILL;
         end else begin
            q_o[p] = oreg[p] ? oq_r[p] : unreg[p];
         end
      end

      always_ff @(posedge ref_clk or negedge rst_b) begin
         if (!rst_b) begin
            rl_d_r[p] <= '0;
            rd_d_r[p] <= 1'b0;
            oq_r[p] <= 36'h0_0000_0000;
            known_r[p] <= 1'b0;
         end else if (clk_en) begin
            rl_d_r[p] <= rl_d_nxt[p];
            rd_d_r[p] <= rd_d_nxt[p];
            oq_r[p] <= oq_nxt[p];
            known_r[p] <= known_nxt[p];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // falling-edge read address for flow-through
   always_comb begin
      nraddr_nxt = nraddr_r;
      nre_nxt = 1'b0;
      if (in_clr && size != SZ_LARGE) begin
         nraddr_nxt = 12'h000;
      end else if (b_ena) begin
         nraddr_nxt = b_addr;
         nre_nxt = b_rden;
      end
   end

   always_ff @(negedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         nraddr_r <= 12'h000;
         nre_r <= 1'b0;
      end else if (clk_en) begin
         nraddr_r <= nraddr_nxt;
         nre_r <= nre_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mixed-port collision in simple dual-port
   always_comb begin
      coll = mode == MD_SIMPLE && m_we[0] && m_re[1] && lw[0].word == lr[1].word;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         coll_d_r <= 1'b0;
      end else if (clk_en) begin
         coll_d_r <= coll;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   emr_dpram u_ram (
      .clk(ref_clk),
      .rst_b(rst_b),
      .ce(clk_en),
      .a_we(m_we[0]),
      .a_wword(lw[0].word),
      .a_wmask(lw[0].mask),
      .a_wdata(m_wdata[0]),
      .a_re(m_re[0]),
      .a_rword(lr[0].word),
      .a_wt(wt[0]),
      .a_rdata(m_rdata[0]),
      .b_we(m_we[1]),
      .b_wword(lw[1].word),
      .b_wmask(lw[1].mask),
      .b_wdata(m_wdata[1]),
      .b_re(m_re[1]),
      .b_rword(lr[1].word),
      .b_wt(wt[1]),
      .b_rdata(m_rdata[1])
   );

   emr_ahb_regs u_regs (
      .clk(ref_clk),
      .rst_b(rst_b),
      .ce(clk_en),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .coll_pulse(coll && clk_en),
      .spc_pulse(spc_pulse),
      .cfg_err(cfg_err),
      .undef_any(undef_any),
      .cfg(cfg)
   );
endmodule

/* test/emr_ram_asserts.sv */
`timescale 1ns/1ps
module emr_ram_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic clk_en,
   input wire logic rst_b,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // clears
   input wire logic in_clr,
   input wire logic out_clr,
   // port a
   input wire logic a_ena,
   input wire logic [11:0] a_addr,
   input wire logic [35:0] a_din,
   input wire logic a_wren,
   input wire logic a_rden,
   input wire logic [35:0] a_q,
   // port b
   input wire logic b_ena,
   input wire logic [11:0] b_addr,
   input wire logic [35:0] b_din,
   input wire logic b_wren,
   input wire logic b_rden,
   input wire logic [35:0] b_q
);
   // shadow of the config register
   logic [14:0] cfg_r, cfg_nxt;
   logic wp_r, wp_nxt;
   logic tk, awr, sgl, idle;
   assign tk = hsel && hready && htrans[1] && hsize == 3'h2 && clk_en;
   assign awr = a_ena && a_wren && !a_rden && clk_en && !wp_r && !in_clr;
   assign sgl = cfg_r[3:2] == 2'h0 && cfg_r[10:7] == 4'h8;
   assign idle = !a_ena && !b_ena && !in_clr && !out_clr && !wp_r && !tk;
   always_comb begin
      wp_nxt = clk_en ? tk && hwrite && haddr == 32'h0 : wp_r;
      cfg_nxt = (clk_en && wp_r) ? hwdata[14:0] : cfg_r;
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= 15'h4405;
         wp_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         wp_r <= wp_nxt;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   a_power_clear: assert property (!$past(rst_b) |-> a_q == 36'h0 && b_q == 36'h0)
      else $error("outputs not cleared after reset");
   a_write_thru: assert property (awr && sgl && !cfg_r[4] ##1
      clk_en && !in_clr && !out_clr && !wp_r |-> ##1 a_q == $past(a_din, 2))
      else $error("write data not shown on port a");
   a_oreg_late: assert property (awr && sgl && cfg_r[4] ##1
      (clk_en && !in_clr && !out_clr && !wp_r) [*2] |-> ##1 a_q == $past(a_din, 3))
      else $error("registered write data late or wrong");
   a_clear_out: assert property (out_clr && clk_en && cfg_r[4] && cfg_r[1:0] != 2'h2
      |=> a_q == 36'h0) else $error("output clear ignored");
   a_coll_fill: assert property (cfg_r[3:0] == 4'h6 && cfg_r[14:7] == 8'h88 && !cfg_r[5]
      && !wp_r && a_ena && a_wren && b_ena && b_rden && clk_en && a_addr[6:0] == b_addr[6:0]
      ##1 clk_en && !out_clr |-> ##1 b_q == 36'hf_ffff_ffff)
      else $error("large collision not undefined");
   a_q_hold: assert property (idle [*4] |-> $stable(a_q) && $stable(b_q))
      else $error("read data moved without access");
   a_cfg_read: assert property (tk && !hwrite && haddr == 32'h0 && !wp_r
      |=> hrdata == {17'h0, cfg_r}) else $error("config read back wrong");
   a_ready_echo: assert property (hreadyout == clk_en) else $error("ready not clock enable");
   a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
   c_write: cover property (awr && sgl);
   c_coll: cover property (cfg_r[1:0] == 2'h2 && a_ena && b_ena);
   c_clear: cover property (out_clr && cfg_r[4]);
endmodule

/* test/emr_user.sv */
`timescale 1ns/1ps
module emr_user (
   // clock
   input wire logic clk,
   // port a
   output logic a_ena,
   output logic [11:0] a_addr,
   output logic [35:0] a_din,
   output logic a_wren,
   output logic a_rden,
   // port b
   output logic b_ena,
   output logic [11:0] b_addr,
   output logic [35:0] b_din,
   output logic b_wren,
   output logic b_rden
);
   logic allow_both = 1'b0;
   logic rom_lock = 1'b0;
   initial {a_ena, a_addr, a_din, a_wren, a_rden, b_ena, b_addr, b_din, b_wren, b_rden} = '0;
   ////////////////////////////////////////
   // one access on one port at the coming edge
   task automatic put(input logic pb, input logic [11:0] ad, input logic [35:0] d,
                      input logic we, input logic re);
      logic w;
      logic r;
      w = we && !rom_lock;
      r = re && !(w && !allow_both);
      if (pb) begin
         {b_ena, b_addr, b_din, b_wren, b_rden} <= {1'b1, ad, d, w, r};
      end else begin
         {a_ena, a_addr, a_din, a_wren, a_rden} <= {1'b1, ad, d, w, r};
      end
   endtask
   task automatic wr(input logic pb, input logic [11:0] ad, input logic [35:0] d);
      put(pb, ad, d, 1'b1, 1'b0);
   endtask
   task automatic rd(input logic pb, input logic [11:0] ad);
      put(pb, ad, pb ? ~b_din : ~a_din, 1'b0, 1'b1);
   endtask
   // released address and data lines show the inverse of their last value
   task automatic rest();
      {a_ena, a_wren, a_rden, b_ena, b_wren, b_rden} <= '0;
      a_addr <= ~a_addr;
      a_din <= ~a_din;
      b_addr <= ~b_addr;
      b_din <= ~b_din;
   endtask
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0;
   logic clk_en, rst_b, hsel, hwrite, hready, hreadyout, hresp, in_clr, out_clr;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic a_ena, a_wren, a_rden, b_ena, b_wren, b_rden;
   logic [11:0] a_addr, b_addr;
   logic [35:0] a_din, b_din, a_q, b_q;
   int num_errors = 0;
   int n_compared = 0;
   localparam logic [31:0] PAT = 32'hc35a_96e1;
   localparam logic [35:0] FILL = 36'hf_ffff_ffff;
   always #5 ref_clk = ~ref_clk;
   assign hready = hreadyout;
   emr_ram_top i_emr_ram_top (.*);
   emr_user i_emr_user (.clk(ref_clk), .*);
   ////////////////////////////////////////
   task automatic summarize();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic look();
      @(negedge ref_clk);
   endtask
   task automatic wait_rdy();
      int i;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
      @(posedge ref_clk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, ad, w};
      wait_rdy();
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      wait_rdy();
      rd = hrdata;
   endtask
   ////////////////////////////////////////
   task automatic s_regs();
      check(a_q, 36'h0);
      check(b_q, 36'h0);
      ahb(1'b0, 32'h0, 32'h0);
      check(rd, 36'h4405);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd, 36'h0);
      ahb(1'b0, 32'h10, 32'h0);
      check(rd, 36'h0);
   endtask
   task automatic s_simple();
      i_emr_user.wr(1'b0, 12'h5, 36'h1_1111_1111);
      tick();
      i_emr_user.wr(1'b0, 12'h6, 36'h2_2222_2222);
      tick();
      i_emr_user.rd(1'b1, 12'h5);
      tick();
      i_emr_user.rest();
      tick();
      look();
      check(b_q, 36'h1_1111_1111);
      ahb(1'b1, 32'h0, 32'h4425);
      i_emr_user.rd(1'b1, 12'h6);
      tick();
      i_emr_user.rest();
      tick();
      look();
      check(b_q, 36'h1_1111_1111);
      tick();
      look();
      check(b_q, 36'h2_2222_2222);
      tick();
      i_emr_user.wr(1'b0, 12'h5, 36'h3_3333_3333);
      i_emr_user.rd(1'b1, 12'h5);
      tick();
      i_emr_user.rest();
      tick(2);
      look();
      check(b_q, 36'h1_1111_1111);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd & 32'h1, 36'h1);
      ahb(1'b1, 32'h4, 32'h1);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd & 32'h1, 36'h0);
      ahb(1'b1, 32'h0, 32'h4406);
      i_emr_user.wr(1'b0, 12'h5, 36'h4_4444_4444);
      i_emr_user.rd(1'b1, 12'h5);
      tick();
      i_emr_user.rest();
      tick();
      look();
      check(b_q, FILL);
      tick();
      i_emr_user.rom_lock = 1'b1;
      i_emr_user.wr(1'b0, 12'h5, 36'h0_0000_0bad);
      tick();
      i_emr_user.rd(1'b1, 12'h5);
      tick();
      i_emr_user.rest();
      i_emr_user.rom_lock = 1'b0;
      tick();
      look();
      check(b_q, 36'h4_4444_4444);
   endtask
   task automatic s_single();
      ahb(1'b1, 32'h0, 32'h4401);
      i_emr_user.wr(1'b0, 12'h9, 36'h5_5555_5555);
      tick();
      i_emr_user.rest();
      tick();
      look();
      check(a_q, 36'h5_5555_5555);
      ahb(1'b1, 32'h0, 32'h4411);
      i_emr_user.wr(1'b0, 12'h9, 36'h6_6666_6666);
      tick();
      i_emr_user.rest();
      tick();
      look();
      check({35'h0, a_q === 36'h6_6666_6666}, 36'h0);
      tick();
      look();
      check(a_q, 36'h6_6666_6666);
      tick();
      i_emr_user.allow_both = 1'b1;
      i_emr_user.put(1'b0, 12'h9, 36'h7_7777_7777, 1'b1, 1'b1);
      tick();
      i_emr_user.rest();
      i_emr_user.allow_both = 1'b0;
      ahb(1'b0, 32'h4, 32'h0);
      check(rd & 32'h2, 36'h2);
      out_clr <= 1'b1;
      tick();
      out_clr <= 1'b0;
      look();
      check(a_q, 36'h0);
      tick();
      in_clr <= 1'b1;
      i_emr_user.wr(1'b0, 12'h9, 36'h0_0000_0bad);
      tick();
      in_clr <= 1'b0;
      i_emr_user.rd(1'b0, 12'h9);
      tick();
      i_emr_user.rest();
      tick(2);
      look();
      check(a_q, 36'h7_7777_7777);
   endtask
   task automatic s_mixed();
      ahb(1'b1, 32'h0, 32'h2005);
      for (int i = 0; i < 32; i++) begin
         i_emr_user.wr(1'b0, 12'(i), {35'h0, PAT[i]});
         tick();
      end
      i_emr_user.rest();
      tick();
      i_emr_user.rd(1'b1, 12'h0);
      tick();
      i_emr_user.rd(1'b1, 12'h1);
      tick();
      i_emr_user.rest();
      look();
      check(b_q[15:0], PAT[15:0]);
      tick();
      look();
      check(b_q[15:0], PAT[31:16]);
   endtask
   // mode 2 shares one store, mode 3 gives each port its own half
   task automatic s_two(input logic [31:0] c, input logic [11:0] wa, input logic [11:0] wb);
      ahb(1'b1, 32'h0, c);
      i_emr_user.wr(1'b0, wa, 36'h8_0000_0001);
      i_emr_user.wr(1'b1, wb, 36'h9_0000_0002);
      tick();
      i_emr_user.rd(1'b0, c[2] ? wa : wb);
      i_emr_user.rd(1'b1, c[2] ? wb : wa);
      tick();
      i_emr_user.rest();
      tick();
      look();
      check(a_q, c[2] ? 36'h8_0000_0001 : 36'h9_0000_0002);
      check(b_q, c[2] ? 36'h9_0000_0002 : 36'h8_0000_0001);
   endtask
   task automatic s_flow();
      ahb(1'b1, 32'h0, 32'h4445);
      i_emr_user.wr(1'b0, 12'h1e, 36'ha_5a5a_5a5a);
      tick();
      i_emr_user.rest();
      tick();
      i_emr_user.rd(1'b1, 12'h1e);
      tick();
      i_emr_user.rest();
      look();
      check(b_q, 36'ha_5a5a_5a5a);
      tick();
      clk_en <= 1'b0;
      i_emr_user.rd(1'b1, 12'h0);
      tick(3);
      clk_en <= 1'b1;
      i_emr_user.rest();
      look();
      check(b_q, 36'ha_5a5a_5a5a);
      tick(6);
   endtask
   ////////////////////////////////////////
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, in_clr, out_clr, rst_b} = '0;
      hsize = 3'h2;
      clk_en = 1'b1;
      tick(10);
      rst_b <= 1'b1;
      s_regs();
      s_simple();
      s_single();
      s_mixed();
      s_two(32'h4409, 12'h14, 12'h15);
      s_two(32'h440d, 12'h2, 12'h2);
      s_flow();
      summarize();
   end
endmodule
bind emr_ram_top emr_ram_asserts i_emr_ram_asserts (.*);
